// ### acc_params.svh
// Purpose: Offsets, field positions, reset values and counts of the conversion control block
// Assumes: Included by its bare name; definitions only
// Notes: Register offsets are word indices on the plain 8-bit register port
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register offsets
`define ACC_OFF_CTRL0 4'h0
`define ACC_OFF_CTRL1 4'h1
`define ACC_OFF_RES_HI 4'h2
`define ACC_OFF_RES_LO 4'h3
`define ACC_OFF_IRQ 4'h4

// Control 0 field positions
`define ACC_C0_START 7
`define ACC_C0_BUSY 6
`define ACC_C0_POWER 5
`define ACC_C0_FORMAT 4
`define ACC_C0_CHAN_HI 3
`define ACC_C0_CHAN_LO 0

// Control 1 field positions
`define ACC_C1_SRC_HI 7
`define ACC_C1_SRC_LO 5
`define ACC_C1_REF_HI 4
`define ACC_C1_REF_LO 3
`define ACC_C1_DIV_HI 2
`define ACC_C1_DIV_LO 0

// Interrupt register field positions
`define ACC_IRQ_GLOBAL 0
`define ACC_IRQ_ENABLE 1
`define ACC_IRQ_FLAG 2

// Reset values
`define ACC_CTRL0_RESET 8'h00
`define ACC_CTRL1_RESET 8'h00
`define ACC_RESULT_RESET 10'h000

// Input source and channel codes
`define ACC_SRC_BANDGAP 3'h1
`define ACC_SRC_AMP0 3'h2
`define ACC_SRC_AMP1 3'h3
`define ACC_SRC_GROUND 3'h4
`define ACC_CHAN_LAST 4'h2

// Conversion timing in converter clock cycles
`define ACC_SAMPLE_TICKS 4
`define ACC_CONV_TICKS 10
`define ACC_TOTAL_TICKS 14

`endif

// ### acc_pkg.sv
// Purpose: Types shared by the conversion control block
// Assumes: Nothing beyond the header of constants
// Notes: Field layouts live in acc_params.svh
`default_nettype none
package acc_pkg;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_HOLD = 2'b01,
      ACC_SAMPLE = 2'b10,
      ACC_CONVERT = 2'b11
   } acc_state_e;

   // Routing handed to the analog front end
   typedef struct packed {
      logic power_on;           // Converter circuitry powered
      logic [2:0] pin_sel;      // One-hot external pin switch
      logic bandgap_sel;        // Bandgap routed in
      logic amp0_sel;           // Op-amp 0 output routed in
      logic amp1_sel;           // Op-amp 1 output routed in
      logic ground_sel;         // Input tied to ground
      logic [1:0] reference_sel; // Full-scale reference choice
   } acc_route_s;

   // Successive approximation drive
   typedef struct packed {
      logic sample;      // Sample switch closed
      logic [9:0] trial; // Trial code to the comparison DAC
   } acc_sar_s;

endpackage
`default_nettype wire

// ### acc_prescaler.sv
// Purpose: Converter clock prescaler, one-cycle tick every 2**sel system clocks
// Assumes: sel is stable while a conversion runs
// Notes: restart clears the count so a conversion starts on a known phase
`timescale 1ns/10ps
`default_nettype none
module acc_prescaler #(
   parameter int DIV_BITS = 3
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic restart,
   input wire logic [DIV_BITS-1:0] sel,
   output logic tick
);
   localparam int CNT_W = (1 << DIV_BITS) - 1;

   logic [CNT_W-1:0] count; // Free-running divide counter
   logic [CNT_W-1:0] mask;  // Low bits that must all be one

   initial begin
      if (DIV_BITS < 1 || DIV_BITS > 4) begin
         $error("acc_prescaler: DIV_BITS out of range");
      end
   end

   // Divide by two to the power of sel; sel zero ticks every cycle
   always_comb begin
      mask = CNT_W'((CNT_W'(1) << sel) - CNT_W'(1));
      tick = ((count & mask) == mask);
   end

   // Counter restarts with the conversion
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else if (restart) begin
         count <= '0;
      end else begin
         count <= count + CNT_W'(1);
      end
   end
endmodule
`default_nettype wire

// ### acc_core.sv
// Purpose: Conversion control of a 10-bit successive approximation converter
// Assumes: Register port strobes are one cycle and never together
// Notes: Analog comparison happens outside; this block sequences and stores the code
// Function
// - Converter clock from system clock, program sets divider
// - Power bit one powers the converter
// - Power bit zero switches converter off
// - Source field picks external or internal signal
// - Two-bit field chooses the full-scale reference
// - Format bit lays result across two bytes
// - Start bit low-high-low starts a conversion
// - Busy high during conversion, low after
// - Result readable in both bytes after busy
// - Result is 10-bit code, full scale reference
// - One step is reference over 1024
// - Transitions half step early, last 1.5 below
// - Divider is two to the field value
// - Conversion is 4 sample plus 10 convert cycles
// - Completion clears busy and sets request flag
// - Source and channel codes decode to inputs
//
// Local design decisions: the address-and-strobe port and the register addresses.
`include "acc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module acc_core
   import acc_pkg::*;
#(
   parameter int RES_BITS = 10,
   parameter int DIV_BITS = 3
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic comp_above,
   output acc_route_s route,
   output acc_sar_s sar,
   output logic irq
);
   localparam int TICK_W = 4;

   initial begin
      if (RES_BITS != 10 || DIV_BITS != 3) begin
         $error("acc_core: only a 10-bit result and 3-bit divider are served");
      end
   end

   // Source codes 000 and 101..111 mean external pins
   function automatic logic src_external(input logic [2:0] src);
      src_external = !(src inside {`ACC_SRC_BANDGAP, `ACC_SRC_AMP0, `ACC_SRC_AMP1, `ACC_SRC_GROUND});
   endfunction

   logic [7:0] ctrl0;          // Start, power, format, channel
   logic [7:0] ctrl1;          // Source, reference, divider
   logic global_irq_enable;    // Global interrupt enable
   logic conversion_irq_enable; // Conversion interrupt enable
   logic conversion_irq_flag;  // Sticky completion request
   logic [9:0] result;         // Last completed code
   logic [9:0] shift_code;     // Code under construction
   logic [TICK_W-1:0] ticks;   // Converter clocks within a phase
   logic start_prev;           // Start bit one cycle ago
   logic tick;                 // Converter clock enable
   logic done;                 // One-cycle completion pulse
   logic sel_wr;               // Raw write strobe, any address
   acc_state_e state;
   acc_state_e next_state;

   wire logic start = ctrl0[`ACC_C0_START];
   wire logic converter_power_on = ctrl0[`ACC_C0_POWER];
   wire logic result_format_sel = ctrl0[`ACC_C0_FORMAT];
   wire logic [3:0] external_channel_sel = ctrl0[`ACC_C0_CHAN_HI:`ACC_C0_CHAN_LO];
   wire logic [2:0] input_source_sel = ctrl1[`ACC_C1_SRC_HI:`ACC_C1_SRC_LO];
   wire logic [1:0] reference_source_sel = ctrl1[`ACC_C1_REF_HI:`ACC_C1_REF_LO];
   wire logic [2:0] adc_clock_divide_sel = ctrl1[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO];
   wire logic conversion_busy_flag = (state == ACC_SAMPLE) || (state == ACC_CONVERT);
   wire logic start_fell = start_prev && !start;

   // Prescaler is held at phase zero until the start bit falls
   acc_prescaler #(.DIV_BITS(DIV_BITS)) u_prescaler (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .restart(state == ACC_HOLD || state == ACC_IDLE),
      .sel(adc_clock_divide_sel),
      .tick(tick)
   );

   // Software writes to the control registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl0 <= `ACC_CTRL0_RESET;
         ctrl1 <= `ACC_CTRL1_RESET;
      end else if (reg_wr && reg_addr == `ACC_OFF_CTRL0) begin
         ctrl0 <= reg_wdata; // Busy position is read-only and ignored on read
      end else if (reg_wr && reg_addr == `ACC_OFF_CTRL1) begin
         ctrl1 <= reg_wdata;
      end
   end

   // Interrupt enables are plain bits
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         global_irq_enable <= 1'b0;
         conversion_irq_enable <= 1'b0;
      end else if (reg_wr && reg_addr == `ACC_OFF_IRQ) begin
         global_irq_enable <= reg_wdata[`ACC_IRQ_GLOBAL];
         conversion_irq_enable <= reg_wdata[`ACC_IRQ_ENABLE];
      end
   end

   // Completion flag: a completion in the clearing cycle still sets it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         conversion_irq_flag <= 1'b0;
      end else if (done) begin
         conversion_irq_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `ACC_OFF_IRQ) begin
         conversion_irq_flag <= reg_wdata[`ACC_IRQ_FLAG];
      end
   end

   // Request reaches the core only with both enables set
   assign irq = conversion_irq_flag && global_irq_enable && conversion_irq_enable;

   // Start bit history for the falling-edge detector
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start;
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         ACC_IDLE: begin
            if (start) begin
               next_state = ACC_HOLD;
            end
         end
         ACC_HOLD: begin
            // Only the fall of start launches; a start left high keeps the hold
            if (start_fell) begin
               next_state = ACC_SAMPLE;
            end
         end
         ACC_SAMPLE: begin
            if (tick && ticks == TICK_W'(`ACC_SAMPLE_TICKS - 1)) begin
               next_state = ACC_CONVERT;
            end
         end
         ACC_CONVERT: begin
            if (tick && ticks == TICK_W'(`ACC_CONV_TICKS - 1)) begin
               next_state = ACC_IDLE;
            end
         end
      endcase
      // Start high restarts any conversion; power off stops everything
      if (start && state != ACC_IDLE) begin
         next_state = ACC_HOLD;
      end
      if (!converter_power_on) begin
         next_state = ACC_IDLE;
      end
   end

   // Completion is the last converting tick with power still on and start low
   assign done = converter_power_on && !start && state == ACC_CONVERT && tick
                 && ticks == TICK_W'(`ACC_CONV_TICKS - 1);

   // Sequencer state register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ACC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Tick counter restarts at each phase change
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ticks <= '0;
      end else if (next_state != state) begin
         ticks <= '0;
      end else if (tick && conversion_busy_flag) begin
         ticks <= ticks + TICK_W'(1);
      end
   end

   // The trial register doubles as the code under construction, so the comparator
   // judges each new trial on the very next cycle, even with the undivided clock
   assign shift_code = sar.trial;

   // Bit decisions MSB first; the DAC is offset half a step by design
   // Trial code and sample switch; trial at step k means (k - 0.5) steps
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sar <= '0;
      end else begin
         sar.sample <= (next_state == ACC_SAMPLE);
         if (state != ACC_CONVERT) begin
            sar.trial <= 10'h200; // First trial at mid scale
         end else if (tick) begin
            sar.trial[9 - ticks] <= comp_above;
            if (ticks != TICK_W'(`ACC_CONV_TICKS - 1)) begin
               sar.trial[8 - ticks] <= 1'b1;
            end
         end
      end
   end

   // Result updates only on completion
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= `ACC_RESULT_RESET;
      end else if (done) begin
         result <= {shift_code[9:1], comp_above};
      end
   end

   // Analog routing; internal sources only with source field set, pins only with an external source code
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         route <= '0;
      end else begin
         route.power_on <= converter_power_on;
         for (int i = 0; i < 3; i++) begin
            route.pin_sel[i] <= converter_power_on && src_external(input_source_sel)
                                && external_channel_sel == 4'(i);
         end
         route.bandgap_sel <= converter_power_on && input_source_sel == `ACC_SRC_BANDGAP;
         route.amp0_sel <= converter_power_on && input_source_sel == `ACC_SRC_AMP0;
         route.amp1_sel <= converter_power_on && input_source_sel == `ACC_SRC_AMP1;
         route.ground_sel <= converter_power_on && input_source_sel == `ACC_SRC_GROUND;
         route.reference_sel <= reference_source_sel;
      end
   end

   // Read data stands in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `ACC_OFF_CTRL0: reg_rdata <= {ctrl0[7], conversion_busy_flag, ctrl0[5:0]};
            `ACC_OFF_CTRL1: reg_rdata <= ctrl1;
            `ACC_OFF_RES_HI: reg_rdata <= result_format_sel ? {6'h00, result[9:8]} : result[9:2];
            `ACC_OFF_RES_LO: reg_rdata <= result_format_sel ? result[7:0] : {result[1:0], 6'h00};
            `ACC_OFF_IRQ: reg_rdata <= {5'h00, conversion_irq_flag, conversion_irq_enable, global_irq_enable};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign sel_wr = reg_wr;

   // Helper: converter clocks counted over one conversion
   logic [4:0] conv_ticks;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_ticks <= '0;
      end else if (!conversion_busy_flag) begin
         conv_ticks <= '0;
      end else if (tick) begin
         conv_ticks <= conv_ticks + 5'h01;
      end
   end

   sequence s_start_pulse;
      start && converter_power_on ##1 !start && converter_power_on;
   endsequence

   a_start_begins_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
      s_start_pulse |=> conversion_busy_flag) else $error("start pulse did not raise busy");
   a_start_holds_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
      start |=> !conversion_busy_flag) else $error("busy while start held high");
   a_power_off_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
      !converter_power_on |=> !conversion_busy_flag && !route.power_on) else $error("active while powered off");
   a_fourteen_ticks: assert property (@(posedge core_clk) disable iff (!arst_n)
      done |-> conv_ticks == 5'(`ACC_TOTAL_TICKS - 1)) else $error("conversion length not 14 clocks");
   a_done_clears_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
      done |=> !conversion_busy_flag && conversion_irq_flag) else $error("completion effects missing");
   a_irq_when_enabled: assert property (@(posedge core_clk) disable iff (!arst_n)
      done && global_irq_enable && conversion_irq_enable && !sel_wr |=> irq) else $error("interrupt not raised");
   a_result_held: assert property (@(posedge core_clk) disable iff (!arst_n)
      !done |=> $stable(result)) else $error("result changed without completion");
   a_undivided_tick: assert property (@(posedge core_clk) disable iff (!arst_n)
      adc_clock_divide_sel == 3'h0 && conversion_busy_flag |-> tick) else $error("undivided clock missed a tick");
   a_divide_two: assert property (@(posedge core_clk) disable iff (!arst_n)
      adc_clock_divide_sel == 3'h1 && $stable(adc_clock_divide_sel) && conversion_busy_flag && tick
      |=> !tick) else $error("divide by two ticked twice");
   a_pin_routing: assert property (@(posedge core_clk) disable iff (!arst_n)
      converter_power_on && src_external(input_source_sel) && external_channel_sel > `ACC_CHAN_LAST
      && $stable(ctrl0) && $stable(ctrl1) |=> route.pin_sel == 3'h0) else $error("floating channel drove a pin");
endmodule
`default_nettype wire

// ### acc_core_tb.sv
// Purpose: Self-checking bench for the conversion control block
// Assumes: Ideal comparator; register strobes one cycle, data seen the cycle after a read
// Notes: Expected values come from bench functions, never from the design outputs
`include "acc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module acc_core_tb
   import acc_pkg::*;
;
   logic core_clk;           // System clock, 40 ns period
   logic arst_n;             // Asynchronous reset, active low
   logic [3:0] reg_addr;     // Register index
   logic [7:0] reg_wdata;    // Write data
   logic reg_wr;             // Write strobe
   logic reg_rd;             // Read strobe
   logic [7:0] reg_rdata;    // Read data
   logic comp_above;         // Comparator answer
   acc_route_s route;        // Analog routing
   acc_sar_s sar;            // Trial code drive
   logic irq;                // Interrupt line
   int mismatches;           // Failed comparisons
   int compares;             // All comparisons
   logic [31:0] seed;        // Xorshift state
   logic [9:0] target;       // Input level as an ideal code
   logic [9:0] last_res;     // Last completed result

   acc_core DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_above(comp_above),
      .route(route), .sar(sar), .irq(irq));

   // Ideal comparator: the half-step offset sits in the DAC, so equal trial keeps the bit
   assign comp_above = (sar.trial <= target);

   // Free-running system clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Hang guard; a run this long means a stuck wait
   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      print_verdict();
   end

   // Repeatable pseudo-random source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected routing for a powered converter
   function automatic acc_route_s exp_route(input logic [2:0] src, input logic [3:0] ch, input logic [1:0] rf);
      acc_route_s r;
      r = '0;
      r.power_on = 1'b1;
      // External pins only for the external codes and existing channels
      if ((src == 3'h0 || src >= 3'h5) && ch <= `ACC_CHAN_LAST) begin
         r.pin_sel = 3'h1 << ch[1:0];
      end
      r.bandgap_sel = (src == `ACC_SRC_BANDGAP);
      r.amp0_sel = (src == `ACC_SRC_AMP0);
      r.amp1_sel = (src == `ACC_SRC_AMP1);
      r.ground_sel = (src == `ACC_SRC_GROUND);
      r.reference_sel = rf;
      return r;
   endfunction

   // Result bytes {high, low} for a format choice
   function automatic logic [15:0] exp_bytes(input logic [9:0] res, input logic fmt);
      return fmt ? {6'h00, res} : {res, 6'h00};
   endfunction

   // One comparison, counted
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Register write: strobe held for exactly one sampling edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Register read: data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Read and compare
   task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string what);
      logic [7:0] v;
      rd(a, v);
      chk(what, {8'h00, e}, {8'h00, v});
   endtask

   // Both result bytes in one format
   task automatic chk_result(input logic [9:0] res, input logic fmt);
      logic [15:0] b;
      b = exp_bytes(res, fmt);
      rchk(`ACC_OFF_RES_HI, b[15:8], "result high");
      rchk(`ACC_OFF_RES_LO, b[7:0], "result low");
   endtask

   // Full conversion with interrupt enabled; timing counted from the start fall
   task automatic convert(input logic [2:0] d, input logic fmt, input logic [9:0] t);
      int n;
      int s;
      n = 0;
      s = 0;
      target = t;
      wr(`ACC_OFF_CTRL1, {3'h0, 2'(rnd()), d});
      wr(`ACC_OFF_CTRL0, {3'b101, fmt, 4'h0});
      wr(`ACC_OFF_CTRL0, {3'b001, fmt, 4'h0});
      #1;
      while (irq !== 1'b1 && n < 2000) begin
         s += (sar.sample === 1'b1) ? 1 : 0;
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 2000) begin
         mismatches++;
         print_verdict();
      end
      // The count starts one edge early, at the edge that lands the start fall
      chk("conversion cycles", 16'((`ACC_TOTAL_TICKS << d) + 1), 16'(n));
      chk("sample cycles", 16'(4 << d), 16'(s));
      rchk(`ACC_OFF_CTRL0, {3'b001, fmt, 4'h0}, "busy after done");
      rchk(`ACC_OFF_IRQ, 8'h07, "request flag");
      chk_result(t, fmt);
      // Format is applied at read time, so flipping it re-lays the same code
      wr(`ACC_OFF_CTRL0, {3'b001, ~fmt, 4'h0});
      chk_result(t, ~fmt);
      last_res = t;
      wr(`ACC_OFF_IRQ, 8'h03);
      #1;
      chk("irq after clear", 16'h0000, {15'h0000, irq});
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [2:0] src;
      logic [3:0] ch;
      logic [1:0] rf;
      logic [2:0] dv;
      logic [7:0] v;
      seed = 32'd20753;
      mismatches = 0;
      compares = 0;
      target = 10'h000;
      last_res = 10'h000;
      arst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk("route in reset", 16'h0000, 16'(route));
      arst_n <= 1'b1;
      // Reset values, unmapped place, read data idle level
      for (int a = 0; a < 8; a++) begin
         rchk(4'(a), 8'h00, "reset value");
      end
      @(posedge core_clk);
      #1;
      chk("read data idle", 16'h0000, {8'h00, reg_rdata});
      wr(4'h9, 8'hff);
      rchk(4'h9, 8'h00, "unmapped read");
      // Every source code, random channels and references; busy bit write ignored
      for (int i = 0; i < 16; i++) begin
         src = 3'(i);
         ch = 4'(rnd()) & ((i < 8) ? 4'h3 : 4'hf);
         rf = 2'(rnd());
         dv = 3'(rnd());
         if (src == 3'h0 || src >= 3'h5) begin
            wr(`ACC_OFF_CTRL1, {src, rf, dv});
            wr(`ACC_OFF_CTRL0, {4'h6, ch});
         end else begin
            // Park the channel on a missing pin before routing an internal signal
            ch = ch | 4'h3;
            wr(`ACC_OFF_CTRL0, {4'h6, ch});
            wr(`ACC_OFF_CTRL1, {src, rf, dv});
         end
         @(posedge core_clk);
         #1;
         chk("route", 16'(exp_route(src, ch, rf)), 16'(route));
         rchk(`ACC_OFF_CTRL1, {src, rf, dv}, "control 1");
         rchk(`ACC_OFF_CTRL0, {4'h2, ch}, "control 0");
      end
      wr(`ACC_OFF_CTRL0, 8'h00);
      @(posedge core_clk);
      #1;
      chk("power off", 16'h0000, {15'h0000, route.power_on});
      // Conversions: end codes, random codes, three divide settings, both formats
      wr(`ACC_OFF_IRQ, 8'h03);
      convert(3'h0, 1'b0, 10'h3ff);
      convert(3'h1, 1'b1, 10'h000);
      for (int k = 0; k < 6; k++) begin
         convert(3'(k % 3), 1'(k), 10'(rnd()));
      end
      // Conversion enable off: flag sets, line stays low
      wr(`ACC_OFF_IRQ, 8'h01);
      wr(`ACC_OFF_CTRL1, 8'h00);
      target = 10'(rnd());
      wr(`ACC_OFF_CTRL0, 8'ha0);
      wr(`ACC_OFF_CTRL0, 8'h20);
      // Poll busy instead of waiting on the masked interrupt
      v = 8'h40;
      for (int p = 0; p < 50 && v[6]; p++) begin
         rd(`ACC_OFF_CTRL0, v);
      end
      if (v[6]) begin
         mismatches++;
         print_verdict();
      end
      chk("masked irq", 16'h0000, {15'h0000, irq});
      rchk(`ACC_OFF_IRQ, 8'h05, "masked flag");
      last_res = target;
      chk_result(last_res, 1'b0);
      wr(`ACC_OFF_IRQ, 8'h00);
      // Start held high keeps the sequencer in hold with busy low
      wr(`ACC_OFF_CTRL0, 8'ha0);
      repeat (40) @(posedge core_clk);
      rchk(`ACC_OFF_CTRL0, 8'ha0, "start held");
      rchk(`ACC_OFF_IRQ, 8'h00, "no flag while held");
      // Power removed mid conversion: abort, no flag, old result kept
      wr(`ACC_OFF_CTRL1, 8'h02);
      target = ~last_res;
      wr(`ACC_OFF_CTRL0, 8'h20);
      rchk(`ACC_OFF_CTRL0, 8'h60, "busy running");
      wr(`ACC_OFF_CTRL0, 8'h00);
      repeat (80) @(posedge core_clk);
      rchk(`ACC_OFF_CTRL0, 8'h00, "busy after abort");
      rchk(`ACC_OFF_IRQ, 8'h00, "no flag after abort");
      chk_result(last_res, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
